// ==== rtl/tteil_irq_ctrl.sv ====
// module: two-tier event interrupt controller with an AXI4-Lite register slave
// What this block does
// (RL1) each event sets its own latching flag
// (RL2) set flag holds after the cause ends
// (RL3) writing one clears a flag, zero ignored
// (RL4) reading flag registers changes nothing
// (RL5) primary interrupt is OR of group flags
// (RL6) per-flag mask removes it from OR
// (RL7) dedicated interrupt pin alerts the host
// (RL8) host reads flags, acts, then clears them
// (RL9) a general pin edge sets a flag if its rise or fall enable is set
// (RL10) temperature reaching warning level sets flag
// (RL11) pin high while any primary is active
`timescale 1ns/1ps
module tteil_irq_ctrl
    import tteil_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic [TTEIL_GPIO_N-1:0] general_pins_1_to_12,
    input wire logic [TTEIL_TEMP_W-1:0] temp_value,
    input wire logic temp_valid,
    input wire logic [TTEIL_MISC_N-1:0] misc_events,
    input wire logic [TTEIL_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [TTEIL_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);
    // pin synchroniser and edge history
    logic [TTEIL_GPIO_N-1:0] gp_s1;
    logic [TTEIL_GPIO_N-1:0] gp_s2;
    logic [TTEIL_GPIO_N-1:0] gp_s3;

    // software-visible control
    logic [TTEIL_GPIO_N-1:0] gpio_mask;
    logic [TTEIL_GPIO_N-1:0] gpio_rise_en;
    logic [TTEIL_GPIO_N-1:0] gpio_fall_en;
    logic [0:0] therm_mask;
    logic [TTEIL_TEMP_W-1:0] therm_level;
    logic [TTEIL_MISC_N-1:0] misc_mask;
    logic therm_above;

    // flag banks
    logic [TTEIL_GPIO_N-1:0] gpio_flags;
    logic [0:0] therm_flags;
    logic [TTEIL_MISC_N-1:0] misc_flags;
    logic gpio_prim;
    logic therm_prim;
    logic misc_prim;

    // bus state
    tteil_wr_t wr_hold;
    logic aw_got;
    logic w_got;

    wire aw_hs = s_axi_awvalid & s_axi_awready;
    wire w_hs = s_axi_wvalid & s_axi_wready;
    wire ar_hs = s_axi_arvalid & s_axi_arready;
    wire do_write = aw_got & w_got & ~s_axi_bvalid;
    wire next_aw_got = (aw_got | aw_hs) & ~do_write;
    wire next_w_got = (w_got | w_hs) & ~do_write;
    wire next_bvalid = do_write | (s_axi_bvalid & ~s_axi_bready);
    wire next_rvalid = ar_hs | (s_axi_rvalid & ~s_axi_rready);

    wire [31:0] strb_bits = {{8{wr_hold.strb[3]}}, {8{wr_hold.strb[2]}},
                             {8{wr_hold.strb[1]}}, {8{wr_hold.strb[0]}}};
    wire [31:0] wr_bits = wr_hold.data & strb_bits;
    wire [31:0] wr_merge_keep = ~strb_bits;

    // write decode
    wire wr_gpio_flag = do_write && (wr_hold.addr == TTEIL_OFS_GPIO_FLAG);
    wire wr_gpio_mask = do_write && (wr_hold.addr == TTEIL_OFS_GPIO_MASK);
    wire wr_gpio_rise = do_write && (wr_hold.addr == TTEIL_OFS_GPIO_RISE);
    wire wr_gpio_fall = do_write && (wr_hold.addr == TTEIL_OFS_GPIO_FALL);
    wire wr_therm_flag = do_write && (wr_hold.addr == TTEIL_OFS_THERM_FLAG);
    wire wr_therm_mask = do_write && (wr_hold.addr == TTEIL_OFS_THERM_MASK);
    wire wr_therm_level = do_write && (wr_hold.addr == TTEIL_OFS_THERM_LEVEL);
    wire wr_misc_flag = do_write && (wr_hold.addr == TTEIL_OFS_MISC_FLAG);
    wire wr_misc_mask = do_write && (wr_hold.addr == TTEIL_OFS_MISC_MASK);
    wire wr_known = wr_gpio_flag | wr_gpio_mask | wr_gpio_rise | wr_gpio_fall | wr_therm_flag |
                    wr_therm_mask | wr_therm_level | wr_misc_flag | wr_misc_mask;
    wire wr_live = do_write && ((wr_hold.addr == TTEIL_OFS_PRIMARY) || (wr_hold.addr == TTEIL_OFS_LIVE));

    // only ones written with their byte lane enabled clear a flag
    wire [TTEIL_GPIO_N-1:0] gpio_clr = wr_gpio_flag ? wr_bits[TTEIL_GPIO_N-1:0] : '0; // [RL3]
    wire [0:0] therm_clr = wr_therm_flag ? wr_bits[0:0] : '0; // [RL3]
    wire [TTEIL_MISC_N-1:0] misc_clr = wr_misc_flag ? wr_bits[TTEIL_MISC_N-1:0] : '0; // [RL3]

    wire [TTEIL_GPIO_N-1:0] next_gpio_mask =
        (gpio_mask & wr_merge_keep[TTEIL_GPIO_N-1:0]) | wr_bits[TTEIL_GPIO_N-1:0];
    wire [TTEIL_GPIO_N-1:0] next_gpio_rise =
        (gpio_rise_en & wr_merge_keep[TTEIL_GPIO_N-1:0]) | wr_bits[TTEIL_GPIO_N-1:0];
    wire [TTEIL_GPIO_N-1:0] next_gpio_fall =
        (gpio_fall_en & wr_merge_keep[TTEIL_GPIO_N-1:0]) | wr_bits[TTEIL_GPIO_N-1:0];
    wire [TTEIL_TEMP_W-1:0] next_therm_level =
        (therm_level & wr_merge_keep[TTEIL_TEMP_W-1:0]) | wr_bits[TTEIL_TEMP_W-1:0];
    wire [TTEIL_MISC_N-1:0] next_misc_mask =
        (misc_mask & wr_merge_keep[TTEIL_MISC_N-1:0]) | wr_bits[TTEIL_MISC_N-1:0];

    // event sources
    wire [TTEIL_GPIO_N-1:0] gp_rise = gp_s2 & ~gp_s3;
    wire [TTEIL_GPIO_N-1:0] gp_fall = ~gp_s2 & gp_s3;
    wire [TTEIL_GPIO_N-1:0] gpio_evt = (gp_rise & gpio_rise_en) | (gp_fall & gpio_fall_en); // [RL9]
    wire temp_hot = temp_valid && (temp_value >= therm_level);
    wire [0:0] therm_evt = temp_hot & ~therm_above; // [RL10]
    wire any_prim = gpio_prim | therm_prim | misc_prim;

    // read decode; a read only selects data and never touches a flag
    wire [31:0] live_word = {15'h0, therm_above, 4'h0, gp_s2};
    wire [31:0] prim_word = {29'h0, misc_prim, therm_prim, gpio_prim};
    wire [7:0] ra = s_axi_araddr;
    wire rd_known = (ra == TTEIL_OFS_PRIMARY) || (ra == TTEIL_OFS_GPIO_FLAG) || (ra == TTEIL_OFS_GPIO_MASK) ||
                    (ra == TTEIL_OFS_GPIO_RISE) || (ra == TTEIL_OFS_GPIO_FALL) || (ra == TTEIL_OFS_THERM_FLAG) ||
                    (ra == TTEIL_OFS_THERM_MASK) || (ra == TTEIL_OFS_THERM_LEVEL) ||
                    (ra == TTEIL_OFS_MISC_FLAG) || (ra == TTEIL_OFS_MISC_MASK) || (ra == TTEIL_OFS_LIVE);
    wire [31:0] rd_data =
        (ra == TTEIL_OFS_PRIMARY) ? prim_word : // [RL5]
        (ra == TTEIL_OFS_GPIO_FLAG) ? {20'h00000, gpio_flags} : // [RL4]
        (ra == TTEIL_OFS_GPIO_MASK) ? {20'h00000, gpio_mask} :
        (ra == TTEIL_OFS_GPIO_RISE) ? {20'h00000, gpio_rise_en} :
        (ra == TTEIL_OFS_GPIO_FALL) ? {20'h00000, gpio_fall_en} :
        (ra == TTEIL_OFS_THERM_FLAG) ? {31'h0, therm_flags} :
        (ra == TTEIL_OFS_THERM_MASK) ? {31'h0, therm_mask} :
        (ra == TTEIL_OFS_THERM_LEVEL) ? {20'h00000, therm_level} :
        (ra == TTEIL_OFS_MISC_FLAG) ? {24'h000000, misc_flags} :
        (ra == TTEIL_OFS_MISC_MASK) ? {24'h000000, misc_mask} :
        (ra == TTEIL_OFS_LIVE) ? live_word : 32'h00000000;
    tteil_rd_t next_rd;
    assign next_rd.data = rd_data;
    assign next_rd.resp = rd_known ? TTEIL_RESP_OKAY : TTEIL_RESP_SLVERR;

    // pins arrive from outside the clock domain
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gp_s1 <= '0;
            gp_s2 <= '0;
            gp_s3 <= '0;
        end else if (ce) begin
            gp_s1 <= general_pins_1_to_12;
            gp_s2 <= gp_s1;
            gp_s3 <= gp_s2;
        end
    end

    // warning level crossing is re-armed once the temperature falls below it
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            therm_above <= 1'b0;
        end else if (ce && temp_valid) begin
            therm_above <= temp_hot; // [RL10]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gpio_mask <= TTEIL_GPIO_MASK_RST;
            gpio_rise_en <= TTEIL_GPIO_RISE_RST;
            gpio_fall_en <= TTEIL_GPIO_FALL_RST;
            therm_mask <= TTEIL_THERM_MASK_RST;
            therm_level <= TTEIL_THERM_LEVEL_RST;
            misc_mask <= TTEIL_MISC_MASK_RST;
        end else if (ce) begin
            if (wr_gpio_mask) gpio_mask <= next_gpio_mask; // [RL6]
            if (wr_gpio_rise) gpio_rise_en <= next_gpio_rise;
            if (wr_gpio_fall) gpio_fall_en <= next_gpio_fall;
            if (wr_therm_mask) therm_mask <= (therm_mask & wr_merge_keep[0:0]) | wr_bits[0:0]; // [RL6]
            if (wr_therm_level) therm_level <= next_therm_level; // [RL10]
            if (wr_misc_mask) misc_mask <= next_misc_mask; // [RL6]
        end
    end

    tteil_flag_bank #(.WIDTH(TTEIL_GPIO_N)) u_gpio_bank (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .set(gpio_evt),
        .clr(gpio_clr),
        .mask(gpio_mask),
        .flags(gpio_flags),
        .primary(gpio_prim)
    );

    tteil_flag_bank #(.WIDTH(1)) u_therm_bank (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .set(therm_evt),
        .clr(therm_clr),
        .mask(therm_mask),
        .flags(therm_flags),
        .primary(therm_prim)
    );

    tteil_flag_bank #(.WIDTH(TTEIL_MISC_N)) u_misc_bank (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .set(misc_events),
        .clr(misc_clr),
        .mask(misc_mask),
        .flags(misc_flags),
        .primary(misc_prim)
    );

    // interrupt pin follows the primaries one cycle later
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= any_prim; // [RL7] [RL11]
        end
    end

    // write channel: address and data taken in either order, answered once both are held
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            wr_hold <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= TTEIL_RESP_OKAY;
        end else if (ce) begin
            if (aw_hs) wr_hold.addr <= s_axi_awaddr;
            if (w_hs) wr_hold.data <= s_axi_wdata;
            if (w_hs) wr_hold.strb <= s_axi_wstrb;
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            s_axi_awready <= ~next_aw_got;
            s_axi_wready <= ~next_w_got;
            s_axi_bvalid <= next_bvalid;
            if (do_write) s_axi_bresp <= (wr_known | wr_live) ? TTEIL_RESP_OKAY : TTEIL_RESP_SLVERR;
        end
    end

    // read channel
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= TTEIL_RESP_OKAY;
        end else if (ce) begin
            s_axi_arready <= ~next_rvalid;
            s_axi_rvalid <= next_rvalid;
            if (ar_hs) s_axi_rdata <= next_rd.data;
            if (ar_hs) s_axi_rresp <= next_rd.resp;
        end
    end

    property p_read_keeps_flags;
        @(posedge clk_sys) disable iff (rst)
        (ce && ar_hs && !do_write) |=> ((gpio_flags & $past(gpio_flags)) == $past(gpio_flags));
    endproperty
    a_read_keeps_flags: assert property (p_read_keeps_flags) else $error("read disturbed flags"); // [RL4]

    property p_primary_read;
        @(posedge clk_sys) disable iff (rst)
        (ce && ar_hs && (s_axi_araddr == TTEIL_OFS_PRIMARY))
            |=> (s_axi_rvalid && (s_axi_rdata[TTEIL_PRI_GPIO] == $past(|(gpio_flags & ~gpio_mask))));
    endproperty
    a_primary_read: assert property (p_primary_read) else $error("primary bit is not OR of flags"); // [RL5]

    property p_masked_out;
        @(posedge clk_sys) disable iff (rst)
        ((gpio_flags & gpio_mask) != '0) && ((gpio_flags & ~gpio_mask) == '0) |-> !gpio_prim;
    endproperty
    a_masked_out: assert property (p_masked_out) else $error("masked flag reached primary"); // [RL6]

    property p_irq_raise;
        @(posedge clk_sys) disable iff (rst)
        (ce && ((gpio_flags & ~gpio_mask) != '0)) |=> irq;
    endproperty
    a_irq_raise: assert property (p_irq_raise) else $error("enabled flag did not raise irq"); // [RL7]

    property p_gpio_edge;
        @(posedge clk_sys) disable iff (rst)
        (ce && ((gp_s2 & ~gp_s3 & gpio_rise_en) != '0))
            |=> ((gpio_flags & $past(gp_s2 & ~gp_s3 & gpio_rise_en)) == $past(gp_s2 & ~gp_s3 & gpio_rise_en));
    endproperty
    a_gpio_edge: assert property (p_gpio_edge) else $error("pin edge did not set flag"); // [RL9]

    property p_therm_warn;
        @(posedge clk_sys) disable iff (rst)
        (ce && temp_valid && (temp_value >= therm_level) && !therm_above) |=> therm_flags[0];
    endproperty
    a_therm_warn: assert property (p_therm_warn) else $error("warning level did not set flag"); // [RL10]

    property p_irq_release;
        @(posedge clk_sys) disable iff (rst)
        (ce && !gpio_prim && !therm_prim && !misc_prim) |=> !irq;
    endproperty
    a_irq_release: assert property (p_irq_release) else $error("irq stayed with no enabled flag"); // [RL11]

    property p_write_answer;
        @(posedge clk_sys) disable iff (rst)
        (ce && aw_got && w_got && !s_axi_bvalid) |=> s_axi_bvalid;
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("write not answered"); // [RL3]

    property p_misc_event;
        @(posedge clk_sys) disable iff (rst)
        (ce && (misc_events != '0)) |=> ((misc_flags & $past(misc_events)) == $past(misc_events));
    endproperty
    a_misc_event: assert property (p_misc_event) else $error("block event did not set its flag"); // [RL1]

    property p_flag_read_back;
        @(posedge clk_sys) disable iff (rst)
        (ce && ar_hs && !do_write && (s_axi_araddr == TTEIL_OFS_MISC_FLAG))
            |=> (s_axi_rdata[TTEIL_MISC_N-1:0] == $past(misc_flags))
                && ((misc_flags & $past(misc_flags)) == $past(misc_flags));
    endproperty
    a_flag_read_back: assert property (p_flag_read_back) else $error("flag read lost a flag"); // [RL4]

    property p_pin_fall;
        @(posedge clk_sys) disable iff (rst)
        (ce && ((gp_fall & gpio_fall_en) != '0))
            |=> ((gpio_flags & $past(gp_fall & gpio_fall_en)) == $past(gp_fall & gpio_fall_en));
    endproperty
    a_pin_fall: assert property (p_pin_fall) else $error("falling pin edge did not set flag"); // [RL9]

    property p_misc_masked;
        @(posedge clk_sys) disable iff (rst)
        ((misc_flags & misc_mask) != '0) && ((misc_flags & ~misc_mask) == '0) |-> !misc_prim;
    endproperty
    a_misc_masked: assert property (p_misc_masked) else $error("masked block flag reached primary"); // [RL6]

    property p_irq_any;
        @(posedge clk_sys) disable iff (rst)
        (ce && (therm_prim || misc_prim)) |=> irq;
    endproperty
    a_irq_any: assert property (p_irq_any) else $error("active primary did not raise irq"); // [RL7]
endmodule // tteil_irq_ctrl

// ==== rtl/tteil_pkg.sv ====
// package: register map, field widths, reset values and bus carriers of the interrupt block
package tteil_pkg;
    localparam int TTEIL_GPIO_N = 12;
    localparam int TTEIL_MISC_N = 8;
    localparam int TTEIL_TEMP_W = 12;
    localparam int TTEIL_ADDR_W = 8;

    localparam logic [7:0] TTEIL_OFS_PRIMARY = 8'h00;
    localparam logic [7:0] TTEIL_OFS_GPIO_FLAG = 8'h04;
    localparam logic [7:0] TTEIL_OFS_GPIO_MASK = 8'h08;
    localparam logic [7:0] TTEIL_OFS_GPIO_RISE = 8'h0c;
    localparam logic [7:0] TTEIL_OFS_GPIO_FALL = 8'h10;
    localparam logic [7:0] TTEIL_OFS_THERM_FLAG = 8'h14;
    localparam logic [7:0] TTEIL_OFS_THERM_MASK = 8'h18;
    localparam logic [7:0] TTEIL_OFS_THERM_LEVEL = 8'h1c;
    localparam logic [7:0] TTEIL_OFS_MISC_FLAG = 8'h20;
    localparam logic [7:0] TTEIL_OFS_MISC_MASK = 8'h24;
    localparam logic [7:0] TTEIL_OFS_LIVE = 8'h28;

    localparam int TTEIL_PRI_GPIO = 0;
    localparam int TTEIL_PRI_THERM = 1;
    localparam int TTEIL_PRI_MISC = 2;
    localparam int TTEIL_LIVE_TEMP_BIT = 16;

    localparam logic [11:0] TTEIL_GPIO_MASK_RST = 12'hfff;
    localparam logic [11:0] TTEIL_GPIO_RISE_RST = 12'hfff;
    localparam logic [11:0] TTEIL_GPIO_FALL_RST = 12'h000;
    localparam logic [0:0] TTEIL_THERM_MASK_RST = 1'h1;
    localparam logic [11:0] TTEIL_THERM_LEVEL_RST = 12'hc00;
    localparam logic [7:0] TTEIL_MISC_MASK_RST = 8'hff;

    localparam logic [1:0] TTEIL_RESP_OKAY = 2'h0;
    localparam logic [1:0] TTEIL_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } tteil_wr_t;

    typedef struct packed {
        logic [31:0] data;
        logic [1:0] resp;
    } tteil_rd_t;
endpackage

// ==== rtl/tteil_flag_bank.sv ====
// module: bank of latching event flags with write-one clear, per-flag mask and a primary OR
`timescale 1ns/1ps
module tteil_flag_bank #(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] clr,
    input wire logic [WIDTH-1:0] mask,
    output logic [WIDTH-1:0] flags,
    output logic primary
);
    wire [WIDTH-1:0] enabled_flags;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_flag
            // a new event beats a clear that lands in the same cycle
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    flags[i] <= 1'b0;
                end else if (ce) begin
                    flags[i] <= set[i] | (flags[i] & ~clr[i]); // [RL1] [RL2] [RL3]
                end
            end
        end
    endgenerate

    assign enabled_flags = flags & ~mask; // [RL6]
    assign primary = |enabled_flags; // [RL5]

    property p_flag_set;
        @(posedge clk_sys) disable iff (rst)
        (ce && (set != '0)) |=> ((flags & $past(set)) == $past(set));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("event did not set its flag"); // [RL1]

    property p_flag_latch;
        @(posedge clk_sys) disable iff (rst)
        (ce && ((flags & ~clr) != '0)) |=> ((flags & $past(flags & ~clr)) == $past(flags & ~clr));
    endproperty
    a_flag_latch: assert property (p_flag_latch) else $error("flag dropped without a clear"); // [RL2]

    property p_flag_clear;
        @(posedge clk_sys) disable iff (rst)
        (ce && ((clr & ~set & flags) != '0)) |=> ((flags & $past(clr & ~set)) == '0);
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("write of one did not clear flag"); // [RL3]
endmodule // tteil_flag_bank

// ==== rtl/unused_placeholder_none.sv ====
// intentionally empty file kept out of the build
`timescale 1ns/1ps

// ==== testbench/tteil_host_model.sv ====
// host-side bus master model that reads and clears interrupt registers
`timescale 1ns/1ps
module tteil_host_model
    import tteil_pkg::*;
(
    input wire logic clk_sys,
    output tteil_wr_t wr,
    output logic awvalid,
    input wire logic awready,
    output logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    output logic rready
);
    int stall = 0;
    logic [3:0] lanes = 4'hf;

    initial begin
        wr = '0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        araddr = 8'h00;
    end

    // host finds the cause by reading, then clears with a one
    task automatic write(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk_sys);
        wr <= '{addr: a, data: d, strb: lanes};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk_sys);
            if (awvalid && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
                wr.addr <= ~a;
            end
            if (wvalid && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
                wr.data <= ~d;
            end
        end
        do @(posedge clk_sys); while (!bvalid);
        bready <= 1'b0;
    endtask

    // released lines show garbage, and rready may lag to stall the slave
    task automatic read(input logic [7:0] a);
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk_sys); while (!arready);
        arvalid <= 1'b0;
        araddr <= ~a;
        repeat (stall) @(posedge clk_sys);
        rready <= 1'b1;
        do @(posedge clk_sys); while (!(rvalid && rready));
        rready <= 1'b0;
    endtask
endmodule // tteil_host_model

// ==== testbench/testbench.sv ====
// self-checking bench for the two-tier interrupt controller
`timescale 1ns/1ps
module testbench
    import tteil_pkg::*;
;
    logic clk_sys = 1'b0, rst = 1'b1, temp_valid = 1'b0;
    logic [11:0] pins = 12'h000, temp_value = 12'h000, p;
    logic [7:0] misc_events = 8'h00, seed = 8'h39, r, b;
    tteil_wr_t hw;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, irq;
    logic [7:0] araddr;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int err_total = 0, samples_checked = 0;
    tteil_rd_t exp_r[$], er;
    logic [1:0] exp_b[$], eb;
    logic [7:0] ra [8];
    logic [31:0] rv [8];

    always #5 clk_sys = ~clk_sys;

    tteil_irq_ctrl uut (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .general_pins_1_to_12(pins),
        .temp_value(temp_value), .temp_valid(temp_valid), .misc_events(misc_events),
        .s_axi_awaddr(hw.addr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(hw.data), .s_axi_wstrb(hw.strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));

    tteil_host_model host (.clk_sys(clk_sys), .wr(hw), .awvalid(awvalid), .awready(awready),
        .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready));

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic check(input logic ok, input string m);
        samples_checked++;
        if (!ok) begin
            err_total++;
            $display("BAD %0t %s", $time, m);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs);
        exp_r.push_back('{data: d, resp: rs});
        host.read(a);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs);
        exp_b.push_back(rs);
        host.write(a, d);
    endtask

    task automatic irq_is(input logic v);
        repeat (3) @(posedge clk_sys);
        check(irq === v, "irq level");
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic complete_run();
        if (exp_r.size() + exp_b.size() != 0) err_total++;
        $display("checked %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // result monitor: each answer on the bus takes the oldest note
    always @(posedge clk_sys) begin
        if (rvalid === 1'b1 && rready === 1'b1) begin
            if (exp_r.size() == 0) check(1'b0, "unexpected read");
            else begin
                er = exp_r.pop_front();
                check(rdata === er.data && rresp === er.resp, "read data or resp");
            end
        end
        if (bvalid === 1'b1 && bready === 1'b1) begin
            if (exp_b.size() == 0) check(1'b0, "unexpected write resp");
            else begin
                eb = exp_b.pop_front();
                check(bresp === eb, "write resp");
            end
        end
    end

    initial begin
        wait_clk(20000);
        err_total++;
        complete_run();
    end

    initial begin
        ra = '{TTEIL_OFS_PRIMARY, TTEIL_OFS_GPIO_FLAG, TTEIL_OFS_GPIO_MASK, TTEIL_OFS_GPIO_RISE,
            TTEIL_OFS_GPIO_FALL, TTEIL_OFS_THERM_MASK, TTEIL_OFS_THERM_LEVEL, TTEIL_OFS_MISC_MASK};
        rv = '{32'h0, 32'h0, {20'h0, TTEIL_GPIO_MASK_RST}, {20'h0, TTEIL_GPIO_RISE_RST},
            {20'h0, TTEIL_GPIO_FALL_RST}, {31'h0, TTEIL_THERM_MASK_RST}, {20'h0, TTEIL_THERM_LEVEL_RST},
            {24'h0, TTEIL_MISC_MASK_RST}};
        wait_clk(16);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) rd(ra[i], rv[i], TTEIL_RESP_OKAY);
        rd(8'h2c, 32'h0, TTEIL_RESP_SLVERR);
        wr(8'h2c, 32'hffffffff, TTEIL_RESP_SLVERR);
        wr(TTEIL_OFS_PRIMARY, 32'h7, TTEIL_RESP_OKAY);
        rd(TTEIL_OFS_PRIMARY, 32'h0, TTEIL_RESP_OKAY);
        irq_is(1'b0);
        $display("test reset values done");

        seed = lfsr(seed);
        r = seed;
        b = r & (~r + 8'h01);
        @(posedge clk_sys);
        misc_events <= r;
        @(posedge clk_sys);
        misc_events <= 8'h00;
        rd(TTEIL_OFS_MISC_FLAG, {24'h0, r}, TTEIL_RESP_OKAY);
        host.stall = 3;
        rd(TTEIL_OFS_MISC_FLAG, {24'h0, r}, TTEIL_RESP_OKAY);
        host.stall = 0;
        rd(TTEIL_OFS_PRIMARY, 32'h0, TTEIL_RESP_OKAY);
        irq_is(1'b0);
        wr(TTEIL_OFS_MISC_MASK, 32'h0, TTEIL_RESP_OKAY);
        rd(TTEIL_OFS_PRIMARY, 32'h4, TTEIL_RESP_OKAY);
        irq_is(1'b1);
        wr(TTEIL_OFS_MISC_FLAG, 32'h0, TTEIL_RESP_OKAY);
        rd(TTEIL_OFS_MISC_FLAG, {24'h0, r}, TTEIL_RESP_OKAY);
        wr(TTEIL_OFS_MISC_FLAG, {24'h0, r ^ b}, TTEIL_RESP_OKAY);
        rd(TTEIL_OFS_MISC_FLAG, {24'h0, b}, TTEIL_RESP_OKAY);
        irq_is(1'b1);
        wr(TTEIL_OFS_MISC_MASK, {24'h0, b}, TTEIL_RESP_OKAY);
        rd(TTEIL_OFS_PRIMARY, 32'h0, TTEIL_RESP_OKAY);
        irq_is(1'b0);
        wr(TTEIL_OFS_MISC_MASK, 32'h0, TTEIL_RESP_OKAY);
        irq_is(1'b1);
        wr(TTEIL_OFS_MISC_FLAG, {24'h0, b}, TTEIL_RESP_OKAY);
        irq_is(1'b0);
        rd(TTEIL_OFS_MISC_FLAG, 32'h0, TTEIL_RESP_OKAY);
        $display("test event flags done");

        seed = lfsr(seed);
        p = 12'h001 << (seed[3:0] % 4'd12);
        wr(TTEIL_OFS_GPIO_MASK, 32'h0, TTEIL_RESP_OKAY);
        pins <= p;
        wait_clk(8);
        rd(TTEIL_OFS_GPIO_FLAG, {20'h0, p}, TTEIL_RESP_OKAY);
        rd(TTEIL_OFS_LIVE, {20'h0, p}, TTEIL_RESP_OKAY);
        irq_is(1'b1);
        wr(TTEIL_OFS_GPIO_RISE, 32'h0, TTEIL_RESP_OKAY);
        wr(TTEIL_OFS_GPIO_FALL, 32'hfff, TTEIL_RESP_OKAY);
        wr(TTEIL_OFS_GPIO_FLAG, {20'h0, p}, TTEIL_RESP_OKAY);
        rd(TTEIL_OFS_GPIO_FLAG, 32'h0, TTEIL_RESP_OKAY);
        pins <= 12'h000;
        wait_clk(8);
        rd(TTEIL_OFS_GPIO_FLAG, {20'h0, p}, TTEIL_RESP_OKAY);
        wr(TTEIL_OFS_GPIO_MASK, {20'h0, p}, TTEIL_RESP_OKAY);
        rd(TTEIL_OFS_PRIMARY, 32'h0, TTEIL_RESP_OKAY);
        irq_is(1'b0);
        wr(TTEIL_OFS_GPIO_MASK, 32'h0, TTEIL_RESP_OKAY);
        irq_is(1'b1);
        wr(TTEIL_OFS_GPIO_FLAG, {20'h0, p}, TTEIL_RESP_OKAY);
        irq_is(1'b0);
        $display("test pin events done");

        host.lanes = 4'h2;
        wr(TTEIL_OFS_THERM_LEVEL, 32'h0000ab55, TTEIL_RESP_OKAY);
        host.lanes = 4'hf;
        rd(TTEIL_OFS_THERM_LEVEL, 32'h00000b00, TTEIL_RESP_OKAY);
        wr(TTEIL_OFS_THERM_LEVEL, 32'h100, TTEIL_RESP_OKAY);
        wr(TTEIL_OFS_THERM_MASK, 32'h0, TTEIL_RESP_OKAY);
        @(posedge clk_sys);
        temp_value <= 12'h0ff;
        temp_valid <= 1'b1;
        wait_clk(3);
        rd(TTEIL_OFS_THERM_FLAG, 32'h0, TTEIL_RESP_OKAY);
        temp_value <= 12'h100;
        wait_clk(3);
        rd(TTEIL_OFS_THERM_FLAG, 32'h1, TTEIL_RESP_OKAY);
        rd(TTEIL_OFS_PRIMARY, 32'h2, TTEIL_RESP_OKAY);
        rd(TTEIL_OFS_LIVE, 32'h10000, TTEIL_RESP_OKAY);
        irq_is(1'b1);
        wr(TTEIL_OFS_THERM_FLAG, 32'h1, TTEIL_RESP_OKAY);
        irq_is(1'b0);
        $display("test thermal warning done");
        wait_clk(4);
        complete_run();
    end
endmodule // testbench
